// [oscillator_select_config_decode.sv]
`timescale 1ns/1ps
// How it works
// R1: the two-bit switch/monitor field gives 11 both, 10 monitor, 01 switching, 00 none.
// R2: secondary select 1 means crystal owning both pins, 0 means external clock and port pins.
// R3: clock-out bit 1 leaves the shared pin as I/O, 0 drives the system clock onto it.
// R4: primary mode 11 disabled, 10 high-speed crystal, 01 standard crystal, 00 external clock.
// R5: two-speed start-up runs only while its enable bit is 1.
// R6: the secondary oscillator is enabled only while its enable bit is 1.
// R7: at reset the pll reference is the fast internal rc if the bit is 1, else primary.
// R8: the programmer must write ones to bits 31-16, 13, 11, 5 and 3.
// R9: the word is sampled once at reset and the decode holds until the next reset.
module oscillator_select_config_decode (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write address
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // axi4-lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read address
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // axi4-lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // port logic for the shared pins
   input  wire logic        port_clock_pin_out,
   input  wire logic        port_clock_pin_oe_n,
   input  wire logic        port_secondary_pin_out,
   input  wire logic        port_secondary_pin_oe_n,
   // pins
   output logic             system_clock_out_pin_out,
   output logic             system_clock_out_pin_oe_n,
   output logic             secondary_osc_output_pin_out,
   output logic             secondary_osc_output_pin_oe_n,
   // decoded clock settings
   output logic             switch_enable,
   output logic             monitor_enable,
   output logic             secondary_crystal,
   output logic [1:0]       primary_oscillator_mode,
   output logic             two_speed_startup_enable,
   output logic             secondary_oscillator_enable,
   output logic             pll_ref_fast_internal_rc,
   output logic             config_valid
);
   // programmed word, written over the bus, takes effect only at reset;
   // power-up value is the erased word
   logic [31:0]              oscillator_selection_config =
      osc_cfg_pkg::CONFIG_RESET;
   logic [31:0]              held_word;
   osc_cfg_pkg::load_state_e load_state;
   logic                     aw_held;
   logic                     w_held;
   logic [7:0]               aw_addr;
   logic [31:0]              w_data;
   logic [3:0]               w_strb;
   logic                     reserved_ok;
   logic                     pins_owned;
   logic                     clk_out_drive;
   logic [1:0]               dec_mode;
   logic                     dec_sw;
   logic                     dec_mon;
   logic                     dec_xtal;
   logic                     dec_two;
   logic                     dec_sen;
   logic                     dec_pll;

   // sample once after reset release, then hold
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         load_state <= osc_cfg_pkg::LOAD_IDLE;
         held_word  <= osc_cfg_pkg::CONFIG_RESET;
      end else begin
         unique case (load_state)
            osc_cfg_pkg::LOAD_IDLE:   load_state <= osc_cfg_pkg::LOAD_SAMPLE;
            osc_cfg_pkg::LOAD_SAMPLE: begin
               held_word  <= oscillator_selection_config; // R9
               load_state <= osc_cfg_pkg::LOAD_HELD;
            end
            osc_cfg_pkg::LOAD_HELD:   load_state <= osc_cfg_pkg::LOAD_HELD;
            default:                  load_state <= osc_cfg_pkg::LOAD_IDLE;
         endcase
      end
   end

   osc_cfg_decode u_decode (
      .word                        (held_word),
      .switch_enable               (dec_sw),
      .monitor_enable              (dec_mon),
      .secondary_crystal           (dec_xtal),
      .secondary_pins_owned        (pins_owned),
      .clock_out_drive             (clk_out_drive),
      .primary_oscillator_mode     (dec_mode),
      .two_speed_startup_enable    (dec_two),
      .secondary_oscillator_enable (dec_sen),
      .pll_ref_fast_internal_rc    (dec_pll),
      .reserved_ok                 (reserved_ok)
   );

   // settings registered so the outputs stay glitch free
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         switch_enable               <= 1'b1;
         monitor_enable              <= 1'b1;
         secondary_crystal           <= 1'b1;
         primary_oscillator_mode     <= 2'h3;
         two_speed_startup_enable    <= 1'b1;
         secondary_oscillator_enable <= 1'b1;
         pll_ref_fast_internal_rc    <= 1'b1;
         config_valid                <= 1'b0;
      end else begin
         switch_enable               <= dec_sw; // R1
         monitor_enable              <= dec_mon; // R1
         secondary_crystal           <= dec_xtal; // R2
         primary_oscillator_mode     <= dec_mode; // R4
         two_speed_startup_enable    <= dec_two; // R5
         secondary_oscillator_enable <= dec_sen; // R6
         pll_ref_fast_internal_rc    <= dec_pll; // R7
         config_valid <= (load_state == osc_cfg_pkg::LOAD_HELD);
      end
   end

   osc_clock_pin_mux u_pins (
      .aclk                          (aclk),
      .clock_out_drive               (clk_out_drive),
      .secondary_pins_owned          (pins_owned),
      .port_clock_pin_out            (port_clock_pin_out),
      .port_clock_pin_oe_n           (port_clock_pin_oe_n),
      .port_secondary_pin_out        (port_secondary_pin_out),
      .port_secondary_pin_oe_n       (port_secondary_pin_oe_n),
      .system_clock_out_pin_out      (system_clock_out_pin_out),
      .system_clock_out_pin_oe_n     (system_clock_out_pin_oe_n),
      .secondary_osc_output_pin_out  (secondary_osc_output_pin_out),
      .secondary_osc_output_pin_oe_n (secondary_osc_output_pin_oe_n)
   );

   // write channel: address and data caught in either order
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held & ~s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (aw_held && w_held) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (aw_held && w_held) begin
         w_held <= 1'b0;
      end
   end

   // only the config word is writable; its new value waits for reset
   // no clear on aresetn: like fuses it must outlive the reset it feeds
   always_ff @(posedge aclk) begin
      if (aresetn && aw_held && w_held &&
          aw_addr[7:2] == osc_cfg_pkg::CONFIG_WORD_OFFSET[7:2]) begin
         for (int i = 0; i < 4; i++) begin
            if (w_strb[i]) begin
               oscillator_selection_config[i*8 +: 8] <= w_data[i*8 +: 8];
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= osc_cfg_pkg::RESP_OKAY;
      end else if (aw_held && w_held) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <=
            (aw_addr[7:2] == osc_cfg_pkg::CONFIG_WORD_OFFSET[7:2]) ?
            osc_cfg_pkg::RESP_OKAY : osc_cfg_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // read channel
   assign s_axi_arready = ~s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= osc_cfg_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= osc_cfg_pkg::RESP_OKAY;
         unique case (s_axi_araddr[7:2])
            osc_cfg_pkg::CONFIG_WORD_OFFSET[7:2]:
               s_axi_rdata <= oscillator_selection_config;
            osc_cfg_pkg::DECODED_OFFSET[7:2]:
               s_axi_rdata <= held_word;
            osc_cfg_pkg::STATUS_OFFSET[7:2]:
               s_axi_rdata <= {30'h0, reserved_ok, config_valid};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= osc_cfg_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // a bus write never reaches the live decode before the next reset
   property held_stable_p;
      @(posedge aclk) disable iff (!aresetn)
      (load_state == osc_cfg_pkg::LOAD_HELD) |=> $stable(held_word);
   endproperty
   AST_HELD_STABLE: assert property (held_stable_p) // R9
      else $error("held word changed after sampling");

   sequence sample_seq;
      load_state == osc_cfg_pkg::LOAD_SAMPLE;
   endsequence
   AST_SAMPLE_CAPTURE: assert property (@(posedge aclk) // R9
      disable iff (!aresetn)
      sample_seq |=> held_word == $past(oscillator_selection_config))
      else $error("word not captured at sampling");

   AST_SWMON: assert property (@(posedge aclk) disable iff (!aresetn) // R1
      ##1 (switch_enable == $past(held_word[14]) &&
           monitor_enable == $past(held_word[15])))
      else $error("switch or monitor decode wrong");

   AST_CLKOUT: assert property (@(posedge aclk) disable iff (!aresetn) // R3
      !held_word[10] |-> (system_clock_out_pin_oe_n == 1'b0 &&
                          system_clock_out_pin_out == aclk))
      else $error("clock not driven on clock-out pin");

   AST_SECPINS: assert property (@(posedge aclk) disable iff (!aresetn) // R2
      held_word[12] |-> secondary_osc_output_pin_oe_n)
      else $error("port drives pin owned by oscillator");

   AST_MODE: assert property (@(posedge aclk) disable iff (!aresetn) // R4
      ##1 primary_oscillator_mode == $past(held_word[9:8]))
      else $error("primary mode decode wrong");

   AST_TWO_SPEED: assert property (@(posedge aclk) disable iff (!aresetn) // R5
      ##1 two_speed_startup_enable == $past(held_word[7]))
      else $error("two-speed enable wrong");

   AST_SEC_EN: assert property (@(posedge aclk) disable iff (!aresetn) // R6
      ##1 secondary_oscillator_enable == $past(held_word[6]))
      else $error("secondary enable wrong");

   AST_PLL_REF: assert property (@(posedge aclk) disable iff (!aresetn) // R7
      ##1 pll_ref_fast_internal_rc == $past(held_word[4]))
      else $error("pll reference decode wrong");

endmodule // oscillator_select_config_decode

// [osc_cfg_pkg.sv]
package osc_cfg_pkg;

   // register byte offsets (word aligned)
   localparam logic [7:0] CONFIG_WORD_OFFSET = 8'h00;
   localparam logic [7:0] DECODED_OFFSET     = 8'h04;
   localparam logic [7:0] STATUS_OFFSET      = 8'h08;

   // configuration word field positions
   localparam int SWITCH_MONITOR_LSB  = 14;
   localparam int SECONDARY_SEL_BIT   = 12;
   localparam int CLOCK_OUT_FUNC_BIT  = 10;
   localparam int PRIMARY_MODE_LSB    = 8;
   localparam int TWO_SPEED_BIT       = 7;
   localparam int SECONDARY_EN_BIT    = 6;
   localparam int PLL_REF_BIT         = 4;
   localparam int OSC_SELECT_LSB      = 0;

   // reserved positions that must be programmed as one
   localparam logic [31:0] RESERVED_MASK = 32'hffff_2828;

   // erased value of the word, all ones, is what software sees after power-up
   localparam logic [31:0] CONFIG_RESET  = 32'hffff_ffff;

   // decode of the switching and monitor field
   localparam logic [1:0] SWMON_BOTH    = 2'h3;
   localparam logic [1:0] SWMON_MONITOR = 2'h2;
   localparam logic [1:0] SWMON_SWITCH  = 2'h1;
   localparam logic [1:0] SWMON_NONE    = 2'h0;

   // primary oscillator modes
   typedef enum logic [1:0] {
      PRIMARY_EXTERNAL_CLOCK_INPUT = 2'h0,
      PRIMARY_STANDARD_CRYSTAL     = 2'h1,
      PRIMARY_HIGH_SPEED_CRYSTAL   = 2'h2,
      PRIMARY_DISABLED             = 2'h3
   } primary_mode_e;

   // loader states, gray coded along the path
   typedef enum logic [1:0] {
      LOAD_IDLE   = 2'b00,
      LOAD_SAMPLE = 2'b01,
      LOAD_HELD   = 2'b11
   } load_state_e;

   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // field extraction used by the decoder for the switch/monitor and primary mode fields
   function automatic logic [1:0] field2(input logic [31:0] w,
                                         input int lsb);
      field2 = w[lsb +: 2];
   endfunction

endpackage

// [osc_cfg_decode.sv]
`timescale 1ns/1ps
module osc_cfg_decode (
   // held configuration word
   input  wire logic [31:0] word,
   // decoded clock settings
   output logic             switch_enable,
   output logic             monitor_enable,
   output logic             secondary_crystal,
   output logic             secondary_pins_owned,
   output logic             clock_out_drive,
   output logic [1:0]       primary_oscillator_mode,
   output logic             two_speed_startup_enable,
   output logic             secondary_oscillator_enable,
   output logic             pll_ref_fast_internal_rc,
   output logic             reserved_ok
);
   logic [1:0] swmon;

   always_comb begin
      swmon = osc_cfg_pkg::field2(word, osc_cfg_pkg::SWITCH_MONITOR_LSB);
      unique case (swmon) // R1
         osc_cfg_pkg::SWMON_BOTH: begin
            switch_enable  = 1'b1;
            monitor_enable = 1'b1;
         end
         osc_cfg_pkg::SWMON_MONITOR: begin
            switch_enable  = 1'b0;
            monitor_enable = 1'b1;
         end
         osc_cfg_pkg::SWMON_SWITCH: begin
            switch_enable  = 1'b1;
            monitor_enable = 1'b0;
         end
         osc_cfg_pkg::SWMON_NONE: begin
            switch_enable  = 1'b0;
            monitor_enable = 1'b0;
         end
      endcase
   end

   // crystal use hands both pins to the oscillator, else to port logic
   assign secondary_crystal    = word[osc_cfg_pkg::SECONDARY_SEL_BIT]; // R2
   assign secondary_pins_owned = word[osc_cfg_pkg::SECONDARY_SEL_BIT]; // R2
   assign clock_out_drive      = ~word[osc_cfg_pkg::CLOCK_OUT_FUNC_BIT]; // R3
   assign primary_oscillator_mode =
      osc_cfg_pkg::field2(word, osc_cfg_pkg::PRIMARY_MODE_LSB); // R4
   assign two_speed_startup_enable =
      word[osc_cfg_pkg::TWO_SPEED_BIT]; // R5
   assign secondary_oscillator_enable =
      word[osc_cfg_pkg::SECONDARY_EN_BIT]; // R6
   assign pll_ref_fast_internal_rc = word[osc_cfg_pkg::PLL_REF_BIT]; // R7
   // a wrongly programmed word is flagged, not corrected
   assign reserved_ok =
      (word & osc_cfg_pkg::RESERVED_MASK) == osc_cfg_pkg::RESERVED_MASK; // R8

endmodule // osc_cfg_decode

// [osc_clock_pin_mux.sv]
`timescale 1ns/1ps
module osc_clock_pin_mux (
   // clock and selection
   input  wire logic aclk,
   input  wire logic clock_out_drive,
   input  wire logic secondary_pins_owned,
   // port logic request for the shared pins
   input  wire logic port_clock_pin_out,
   input  wire logic port_clock_pin_oe_n,
   input  wire logic port_secondary_pin_out,
   input  wire logic port_secondary_pin_oe_n,
   // shared clock-out pin
   output logic      system_clock_out_pin_out,
   output logic      system_clock_out_pin_oe_n,
   // secondary output pin, released to the oscillator when owned
   output logic      secondary_osc_output_pin_out,
   output logic      secondary_osc_output_pin_oe_n
);
   // the system clock itself is forwarded; a gated buffer in real silicon
   always_comb begin
      if (clock_out_drive) begin // R3
         system_clock_out_pin_out  = aclk;
         system_clock_out_pin_oe_n = 1'b0;
      end else begin
         system_clock_out_pin_out  = port_clock_pin_out;
         system_clock_out_pin_oe_n = port_clock_pin_oe_n;
      end
   end

   always_comb begin
      if (secondary_pins_owned) begin // R2
         secondary_osc_output_pin_out  = 1'b0;
         secondary_osc_output_pin_oe_n = 1'b1;
      end else begin
         secondary_osc_output_pin_out  = port_secondary_pin_out;
         secondary_osc_output_pin_oe_n = port_secondary_pin_oe_n;
      end
   end

endmodule // osc_clock_pin_mux

// [osc_source_model.sv]
`timescale 1ns/1ps
module osc_source_model #(
   parameter real HALF_NS = 16.1
) (
   // device side of the secondary output pin
   input  wire logic pin_out,
   input  wire logic pin_oe_n,
   // source and resolved wire
   output logic      src_level,
   output logic      pin_level
);
   // a crystal never stops; period kept off the bench clock edges
   initial src_level = 1'b0;
   always #(HALF_NS) src_level = ~src_level;

   // released pin belongs to the oscillator, driven pin to the device
   assign pin_level = pin_oe_n ? src_level : pin_out;
endmodule // osc_source_model

// [test_oscillator_select_config_decode.sv]
`timescale 1ns/1ps
module test_oscillator_select_config_decode;
   localparam int          CEILING  = 3000;
   localparam logic [31:0] ALL1     = osc_cfg_pkg::CONFIG_RESET;
   localparam logic [31:0] WORD_A   = 32'hffff_6a68;
   // reserved positions left at zero on purpose
   localparam logic [31:0] WORD_B   = 32'h0000_9590;
   localparam logic [7:0]  HOLE     = 8'h0c;
   localparam logic [1:0]  OK       = osc_cfg_pkg::RESP_OKAY;
   localparam logic [31:0] STAT_EXP = {30'h0, (ALL1 &
      osc_cfg_pkg::RESERVED_MASK) == osc_cfg_pkg::RESERVED_MASK, 1'b1};

   logic        aclk, aresetn;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic        port_clock_pin_out, port_clock_pin_oe_n;
   logic        port_secondary_pin_out, port_secondary_pin_oe_n;
   logic        system_clock_out_pin_out, system_clock_out_pin_oe_n;
   logic        secondary_osc_output_pin_out, secondary_osc_output_pin_oe_n;
   logic        switch_enable, monitor_enable, secondary_crystal;
   logic [1:0]  primary_oscillator_mode;
   logic        two_speed_startup_enable, secondary_oscillator_enable;
   logic        pll_ref_fast_internal_rc, config_valid;
   logic        src_level, sec_wire;
   int          num_errors = 0;
   int          tests_run  = 0;
   int          cycles     = 0;

   oscillator_select_config_decode dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .port_clock_pin_out(port_clock_pin_out),
      .port_clock_pin_oe_n(port_clock_pin_oe_n),
      .port_secondary_pin_out(port_secondary_pin_out),
      .port_secondary_pin_oe_n(port_secondary_pin_oe_n),
      .system_clock_out_pin_out(system_clock_out_pin_out),
      .system_clock_out_pin_oe_n(system_clock_out_pin_oe_n),
      .secondary_osc_output_pin_out(secondary_osc_output_pin_out),
      .secondary_osc_output_pin_oe_n(secondary_osc_output_pin_oe_n),
      .switch_enable(switch_enable), .monitor_enable(monitor_enable),
      .secondary_crystal(secondary_crystal),
      .primary_oscillator_mode(primary_oscillator_mode),
      .two_speed_startup_enable(two_speed_startup_enable),
      .secondary_oscillator_enable(secondary_oscillator_enable),
      .pll_ref_fast_internal_rc(pll_ref_fast_internal_rc),
      .config_valid(config_valid)
   );

   osc_source_model sec_source (
      .pin_out(secondary_osc_output_pin_out),
      .pin_oe_n(secondary_osc_output_pin_oe_n),
      .src_level(src_level), .pin_level(sec_wire)
   );

   initial aclk = 1'b0;
   always #2.5 aclk = ~aclk;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict;
      if (num_errors == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // a hang ends in the same closing report
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == CEILING) begin
         num_errors++;
         give_verdict();
      end
   end

   // entered just after an edge; an edge passes before returning
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                            output logic [1:0] resp);
      logic aw_open;
      logic w_open;
      aw_open = 1'b1;
      w_open  = 1'b1;
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= 4'hf;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      forever begin
         @(posedge aclk);
         if (!aw_open && !w_open && s_axi_bvalid === 1'b1) begin
            resp = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
         if (aw_open && s_axi_awready === 1'b1) begin
            aw_open = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w_open && s_axi_wready === 1'b1) begin
            w_open = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      @(posedge aclk);
   endtask

   task automatic rd_check(input logic [7:0] a, input logic [31:0] exp,
                           input logic [1:0] exp_resp);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready === 1'b1) begin
            s_axi_arvalid <= 1'b0;
         end
      end while (s_axi_rvalid !== 1'b1);
      check(s_axi_rdata, exp);
      check(s_axi_rresp, exp_resp);
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic do_reset;
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (7) @(posedge aclk);
      #1;
      check(config_valid, 1'b0);
      @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      #1;
      check(config_valid, 1'b1);
      @(posedge aclk);
   endtask

   // decode of the word held since the last reset
   task automatic check_decode(input logic [31:0] w);
      check(monitor_enable, w[15]);
      check(switch_enable, w[14]);
      check(secondary_crystal, w[12]);
      check(primary_oscillator_mode, w[9:8]);
      check(two_speed_startup_enable, w[7]);
      check(secondary_oscillator_enable, w[6]);
      check(pll_ref_fast_internal_rc, w[4]);
   endtask

   initial begin
      logic [1:0] r;
      aresetn = 1'b0;
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
      {s_axi_arvalid, s_axi_rready} = '0;
      {port_clock_pin_out, port_clock_pin_oe_n} = 2'h1;
      {port_secondary_pin_out, port_secondary_pin_oe_n} = 2'h1;
      do_reset();
      check_decode(ALL1);
      rd_check(osc_cfg_pkg::CONFIG_WORD_OFFSET, ALL1, OK);
      rd_check(osc_cfg_pkg::DECODED_OFFSET, ALL1, OK);
      rd_check(osc_cfg_pkg::STATUS_OFFSET, STAT_EXP, OK);
      // a later write must not reach the held decode
      axi_write(osc_cfg_pkg::CONFIG_WORD_OFFSET, WORD_A, r);
      check(r, OK);
      rd_check(osc_cfg_pkg::CONFIG_WORD_OFFSET, WORD_A, OK);
      rd_check(osc_cfg_pkg::DECODED_OFFSET, ALL1, OK);
      check_decode(ALL1);
      axi_write(osc_cfg_pkg::CONFIG_WORD_OFFSET, 32'h0000_0000, r);
      check(r, OK);
      rd_check(osc_cfg_pkg::STATUS_OFFSET, STAT_EXP, OK);
      // unmapped place: refused, no side effect
      axi_write(HOLE, 32'h5a5a_5a5a, r);
      check(r, osc_cfg_pkg::RESP_SLVERR);
      rd_check(HOLE, 32'h0, osc_cfg_pkg::RESP_SLVERR);
      rd_check(osc_cfg_pkg::CONFIG_WORD_OFFSET, 32'h0, OK);
      // every port request on both shared pins
      for (int i = 0; i < 16; i++) begin
         port_clock_pin_out      <= i[3];
         port_clock_pin_oe_n     <= i[2];
         port_secondary_pin_out  <= i[1];
         port_secondary_pin_oe_n <= i[0];
         @(negedge aclk);
         check(system_clock_out_pin_out, i[3]);
         check(system_clock_out_pin_oe_n, i[2]);
         check(secondary_osc_output_pin_out, 1'b0);
         check(secondary_osc_output_pin_oe_n, 1'b1);
         check(sec_wire, src_level);
         @(posedge aclk);
      end
      // second reset: the stored word survives and is resampled
      axi_write(osc_cfg_pkg::CONFIG_WORD_OFFSET, WORD_A, r);
      do_reset();
      check_decode(WORD_A);
      rd_check(osc_cfg_pkg::CONFIG_WORD_OFFSET, WORD_A, OK);
      rd_check(osc_cfg_pkg::DECODED_OFFSET, WORD_A, OK);
      rd_check(osc_cfg_pkg::STATUS_OFFSET, STAT_EXP, OK);
      // clock drives the clock-out pin, secondary pins back to port logic
      port_secondary_pin_oe_n <= 1'b0;
      @(negedge aclk);
      check(system_clock_out_pin_oe_n, 1'b0);
      check(system_clock_out_pin_out, 1'b0);
      check(secondary_osc_output_pin_oe_n, 1'b0);
      check(secondary_osc_output_pin_out, 1'b1);
      check(sec_wire, 1'b1);
      @(posedge aclk);
      #1;
      check(system_clock_out_pin_out, 1'b1);
      @(posedge aclk);
      // third reset: a word with reserved positions at zero is flagged
      axi_write(osc_cfg_pkg::CONFIG_WORD_OFFSET, WORD_B, r);
      check(r, OK);
      do_reset();
      check_decode(WORD_B);
      check(secondary_osc_output_pin_oe_n, 1'b1);
      rd_check(osc_cfg_pkg::STATUS_OFFSET, 32'h0000_0001, OK);
      give_verdict();
   end
endmodule // test_oscillator_select_config_decode
